// *** include/scadc_params.svh ***
// Purpose: timing counts and reset values shared by both ends of the serial readout link
// Assumes: system clock of 40 MHz on both ends
// Notes: times are in ns; cycle counts are derived from them
`ifndef SCADC_PARAMS_SVH
`define SCADC_PARAMS_SVH

`define SCADC_CLK_MHZ 40
// longest wait from conversion start until the lead header zero is on the data line
`define SCADC_MSB_READY_NS 200
`define SCADC_MSB_READY_CYC ((`SCADC_MSB_READY_NS * `SCADC_CLK_MHZ + 999) / 1000)
// point in the next conversion by which the burst must be over
`define SCADC_CLK_DEADLINE_NS 150
`define SCADC_CLK_DEADLINE_CYC ((`SCADC_CLK_DEADLINE_NS * `SCADC_CLK_MHZ) / 1000)
// longest high time of the start pulse; a longest time rounds down
// a two-cycle pulse is the shortest that survives the receiver's three-flop filter
`define SCADC_START_HIGH_MAX_NS 50
`define SCADC_START_HIGH_CYC ((`SCADC_START_HIGH_MAX_NS * `SCADC_CLK_MHZ) / 1000)
// largest spacing between conversions that keeps results valid
`define SCADC_CONV_PERIOD_NS 10000
`define SCADC_CONV_PERIOD_CYC ((`SCADC_CONV_PERIOD_NS * `SCADC_CLK_MHZ) / 1000)
// extra host wait covering the device's input synchroniser
// two more than the three-stage sync depth, so the first sample cannot see the previous low bit
`define SCADC_SYNC_MARGIN_CYC 5
// link clock half period in system cycles, and the three sampling phases
`define SCADC_HALF_CYC 3
`define SCADC_PERIOD_CYC 6
`define SCADC_PHASE_STEP_CYC 2
// pulses per burst, header width, result width, samples taken per phase
`define SCADC_PULSES 18
`define SCADC_HDR_BITS 2
`define SCADC_WORD_BITS 16
`define SCADC_SAMPLES 24
// reset level of the data line and the idle level of the link clock
`define SCADC_DATA_RST 1'h0
`define SCADC_CLK_IDLE 1'h1

`endif

// *** include/scadc_pkg.sv ***
// Purpose: shared types of the serial readout link
// Assumes: scadc_params.svh for the numbers
// Notes: no constants live here
`default_nettype none
package scadc_pkg;
  typedef logic [15:0] scadc_word_type;
  typedef enum {SCADC_H_IDLE, SCADC_H_START, SCADC_H_WAIT, SCADC_H_BURST, SCADC_H_TAIL,
                SCADC_H_DONE} scadc_host_state_type;
  typedef enum {SCADC_D_IDLE, SCADC_D_CONVERT} scadc_conv_state_type;
endpackage : scadc_pkg
`default_nettype wire

// *** include/scadc_link_if.sv ***
// Purpose: the three wires between one converter and its host
// Assumes: both ends run their own 40 MHz clock
// Notes: a shared burst clock to several converters is one link_clk fanned out
`default_nettype none
interface scadc_link_if;
  logic conv_start; // conversion start, rising edge starts a conversion
  logic link_clk;   // host burst clock, idle high
  logic data;       // serial data from the converter
  modport device (input conv_start, input link_clk, output data);
  modport host (output conv_start, output link_clk, input data);
endinterface : scadc_link_if
`default_nettype wire

// *** src/scadc_device.sv ***
// Purpose: converter end: conversion control and self-clocked serial readout
// Assumes: start and link clock come from another clock domain
// Notes: the analogue sample is stood in for by a parallel input word
// Contract
// - header zero one zero precedes each word
// - lead zero present at msb ready time
// - one then zero on falls one, two
// - host ends start pulse within high max
// - started conversion always runs to completion
// - starts during a conversion are ignored
// - host bursts only after msb ready time
// - host gives exactly eighteen pulses in window
// - late burst loses result to next one
// - host idles clock high between bursts
// - each new result shifts on falling edges
// - no data clock is returned to host
// - one shared clock, one data line each
// - host samples on three phases, 120 degrees
// - host picks phase with correct header one
// - conversion starts on start rising edge
// - first result and stale results are invalid
`include "scadc_params.svh"
`default_nettype none
module scadc_device (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [15:0] sample_i,
  output logic busy_o,
  output logic shifting_o,
  scadc_link_if.device link
);

  // three-stage synchronisers for start and link clock
  logic [2:0] start_sync_reg, start_sync_next;
  logic [2:0] clk_sync_reg, clk_sync_next;
  logic start_lvl_reg, start_lvl_next;
  logic clk_lvl_reg, clk_lvl_next;
  logic start_rise;
  logic clk_fall;

  // conversion control state
  scadc_pkg::scadc_conv_state_type conv_state_reg, conv_state_next;
  logic [15:0] conv_cnt_reg, conv_cnt_next;
  scadc_pkg::scadc_word_type held_reg, held_next;
  logic primed_reg, primed_next;
  logic [15:0] gap_cnt_reg, gap_cnt_next;
  logic stale_reg, stale_next;
  logic deadline;
  logic msb_ready;

  // readout state
  logic [17:0] shift_reg, shift_next;
  logic [4:0] fall_cnt_reg, fall_cnt_next;
  logic active_reg, active_next;
  logic data_reg, data_next;
  logic busy_reg, busy_next;

  // synchroniser next values; stage one feeds only stage two
  always_comb begin
    start_sync_next = {start_sync_reg[1:0], link.conv_start};
    clk_sync_next = {clk_sync_reg[1:0], link.link_clk};
    start_lvl_next = start_lvl_reg;
    clk_lvl_next = clk_lvl_reg;
    // a change counts only once stages two and three agree
    if (start_sync_reg[1] == start_sync_reg[2]) begin
      start_lvl_next = start_sync_reg[2];
    end
    if (clk_sync_reg[1] == clk_sync_reg[2]) begin
      clk_lvl_next = clk_sync_reg[2];
    end
  end

  // synchroniser registers; clock level resets to its idle high
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_sync_reg <= 3'h0;
      clk_sync_reg <= {3{`SCADC_CLK_IDLE}};
      start_lvl_reg <= 1'h0;
      clk_lvl_reg <= `SCADC_CLK_IDLE;
    end else if (ce_i) begin
      start_sync_reg <= start_sync_next;
      clk_sync_reg <= clk_sync_next;
      start_lvl_reg <= start_lvl_next;
      clk_lvl_reg <= clk_lvl_next;
    end
  end

  assign start_rise = start_lvl_next & ~start_lvl_reg;
  assign clk_fall = ~clk_lvl_next & clk_lvl_reg;
  assign msb_ready = (conv_state_reg == scadc_pkg::SCADC_D_CONVERT) &&
                     (conv_cnt_reg == 16'(`SCADC_MSB_READY_CYC - 1));
  assign deadline = (conv_state_reg == scadc_pkg::SCADC_D_CONVERT) &&
                    (conv_cnt_reg == 16'(`SCADC_CLK_DEADLINE_CYC - 1));

  // conversion control: the internal conversion ends at msb ready time
  always_comb begin
    conv_state_next = conv_state_reg;
    conv_cnt_next = conv_cnt_reg;
    held_next = held_reg;
    primed_next = primed_reg;
    stale_next = stale_reg;
    busy_next = busy_reg;
    gap_cnt_next = gap_cnt_reg;
    // saturating spacing counter since the last start
    if (gap_cnt_reg != 16'(`SCADC_CONV_PERIOD_CYC)) begin
      gap_cnt_next = gap_cnt_reg + 16'h0001;
    end
    case (conv_state_reg)
      scadc_pkg::SCADC_D_IDLE: begin
        // sample taken on the rising start edge
        if (start_rise) begin
          conv_state_next = scadc_pkg::SCADC_D_CONVERT;
          conv_cnt_next = 16'h0000;
          held_next = sample_i;
          busy_next = 1'h1;
          gap_cnt_next = 16'h0000;
          // spacing over the period spoils this result
          stale_next = (gap_cnt_reg == 16'(`SCADC_CONV_PERIOD_CYC));
        end
      end
      scadc_pkg::SCADC_D_CONVERT: begin
        // no input can abort a running conversion
        // further start edges are not looked at here
        conv_cnt_next = conv_cnt_reg + 16'h0001;
        if (msb_ready) begin
          conv_state_next = scadc_pkg::SCADC_D_IDLE;
          busy_next = 1'h0;
          primed_next = 1'h1;
        end
      end
      default: begin
        conv_state_next = scadc_pkg::SCADC_D_IDLE;
        busy_next = 1'h0;
      end
    endcase
  end

  // conversion registers; spacing counter starts saturated so power-up is stale
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_state_reg <= scadc_pkg::SCADC_D_IDLE;
      conv_cnt_reg <= 16'h0000;
      held_reg <= 16'h0000;
      primed_reg <= 1'h0;
      stale_reg <= 1'h0;
      busy_reg <= 1'h0;
      gap_cnt_reg <= 16'(`SCADC_CONV_PERIOD_CYC);
    end else if (ce_i) begin
      conv_state_reg <= conv_state_next;
      conv_cnt_reg <= conv_cnt_next;
      held_reg <= held_next;
      primed_reg <= primed_next;
      stale_reg <= stale_next;
      busy_reg <= busy_next;
      gap_cnt_reg <= gap_cnt_next;
    end
  end

  // readout shifter; only the data line goes back, no clock is echoed
  always_comb begin
    shift_next = shift_reg;
    fall_cnt_next = fall_cnt_reg;
    active_next = active_reg;
    data_next = data_reg;
    if (msb_ready) begin
      // lead zero on the line with no clock edge
      data_next = 1'h0;
      active_next = 1'h1;
      fall_cnt_next = 5'h00;
      // header one, zero ahead of the word
      // first result after reset goes out as zero
      shift_next = {2'h2, (primed_reg && !stale_reg) ? held_reg : 16'h0000};
    end else if (deadline) begin
      // an unfinished burst is dropped; the line rests low
      active_next = 1'h0;
      data_next = 1'h0;
    end else if (active_reg && clk_fall) begin
      // falls one and two send the header tail
      // falls three to eighteen send the word msb first
      data_next = shift_reg[17];
      shift_next = {shift_reg[16:0], 1'h0};
      fall_cnt_next = fall_cnt_reg + 5'h01;
      // extra falls after the eighteenth are ignored; d0 stays on the line
      if (fall_cnt_reg == 5'(`SCADC_PULSES - 1)) begin
        active_next = 1'h0;
      end
    end
  end

  // readout registers
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_reg <= 18'h00000;
      fall_cnt_reg <= 5'h00;
      active_reg <= 1'h0;
      data_reg <= `SCADC_DATA_RST;
    end else if (ce_i) begin
      shift_reg <= shift_next;
      fall_cnt_reg <= fall_cnt_next;
      active_reg <= active_next;
      data_reg <= data_next;
    end
  end

  // data line only, straight from a flop
  assign link.data = data_reg;
  assign busy_o = busy_reg;
  assign shifting_o = active_reg;

endmodule : scadc_device
`default_nettype wire

// *** src/scadc_host.sv ***
// Purpose: host end: starts conversions, bursts the link clock, aligns capture phase
// Assumes: one instance per converter data line
// Notes: the link clock is divided from the host clock
`include "scadc_params.svh"
`default_nettype none
module scadc_host (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic start_i,
  output logic ready_o,
  output logic [15:0] result_o,
  output logic valid_o,
  output logic error_o,
  output logic [1:0] phase_o,
  scadc_link_if.host link
);

  // finds the header one in a phase's samples; bit 16 set when header is whole
  function automatic logic [16:0] scadc_decode(input logic [23:0] s);
    logic [16:0] r;
    logic found;
    r = 17'h00000;
    found = 1'h0;
    for (int i = 23; i >= 17; i--) begin
      if (!found && s[i]) begin
        found = 1'h1;
        r[16] = ~s[i - 1];
        for (int j = 0; j < 16; j++) begin
          r[15 - j] = s[i - 2 - j];
        end
      end
    end
    return r;
  endfunction

  scadc_pkg::scadc_host_state_type state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [2:0] div_reg, div_next;
  logic [4:0] per_reg, per_next;
  logic lclk_reg, lclk_next;
  logic cnv_reg, cnv_next;
  logic [2:0] din_sync_reg;
  logic din_lvl_reg, din_lvl_next;
  logic [23:0] cap_reg [3], cap_next [3];
  logic [15:0] gap_reg, gap_next;
  logic first_reg, first_next;
  logic spoil_reg, spoil_next;
  logic [15:0] res_reg, res_next;
  logic valid_reg, valid_next;
  logic err_reg, err_next;
  logic [1:0] ph_reg, ph_next;
  logic sampling;
  logic [16:0] dec [3];

  // data pin synchroniser, change taken once stages two and three agree
  always_comb begin
    din_lvl_next = (din_sync_reg[1] == din_sync_reg[2]) ? din_sync_reg[2] : din_lvl_reg;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      din_sync_reg <= 3'h0;
      din_lvl_reg <= 1'h0;
    end else if (ce_i) begin
      din_sync_reg <= {din_sync_reg[1:0], link.data};
      din_lvl_reg <= din_lvl_next;
    end
  end

  assign sampling = (state_reg == scadc_pkg::SCADC_H_BURST) ||
                    (state_reg == scadc_pkg::SCADC_H_TAIL);

  // three decoders, one per sampling phase
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_phase
      assign dec[g] = scadc_decode(cap_reg[g]);
    end
  endgenerate

  // sequencer, clock divider and phase capture
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    div_next = div_reg;
    per_next = per_reg;
    lclk_next = `SCADC_CLK_IDLE;
    cnv_next = 1'h0;
    cap_next = cap_reg;
    first_next = first_reg;
    spoil_next = spoil_reg;
    res_next = res_reg;
    valid_next = 1'h0;
    err_next = err_reg;
    ph_next = ph_reg;
    gap_next = (gap_reg == 16'(`SCADC_CONV_PERIOD_CYC)) ? gap_reg : gap_reg + 16'h0001;
    if (sampling) begin
      div_next = (div_reg == 3'(`SCADC_PERIOD_CYC - 1)) ? 3'h0 : div_reg + 3'h1;
      // phases two cycles apart in a six-cycle period
      for (int p = 0; p < 3; p++) begin
        if (div_reg == 3'(p * `SCADC_PHASE_STEP_CYC)) begin
          cap_next[p] = {cap_reg[p][22:0], din_lvl_reg};
        end
      end
    end
    case (state_reg)
      scadc_pkg::SCADC_H_IDLE: begin
        if (start_i) begin
          state_next = scadc_pkg::SCADC_H_START;
          cnt_next = 16'h0000;
          cnv_next = 1'h1;
          // a long gap spoils the coming result
          spoil_next = (gap_reg == 16'(`SCADC_CONV_PERIOD_CYC));
          gap_next = 16'h0000;
        end
      end
      scadc_pkg::SCADC_H_START: begin
        cnt_next = cnt_reg + 16'h0001;
        // start pulse held no longer than the high maximum
        cnv_next = (cnt_reg + 16'h0001) < 16'(`SCADC_START_HIGH_CYC);
        if (!cnv_next) begin
          state_next = scadc_pkg::SCADC_H_WAIT;
        end
      end
      scadc_pkg::SCADC_H_WAIT: begin
        cnt_next = cnt_reg + 16'h0001;
        // burst only once msb ready time has passed
        if (cnt_reg == 16'(`SCADC_MSB_READY_CYC + `SCADC_SYNC_MARGIN_CYC)) begin
          state_next = scadc_pkg::SCADC_H_BURST;
          div_next = 3'h0;
          per_next = 5'h00;
          for (int p = 0; p < 3; p++) begin
            cap_next[p] = 24'h000000;
          end
        end
      end
      scadc_pkg::SCADC_H_BURST: begin
        // low in cycles one to three of a period, so the last period ends high
        lclk_next = (div_next == 3'h0) || (div_next > 3'(`SCADC_HALF_CYC));
        if (div_reg == 3'(`SCADC_PERIOD_CYC - 1)) begin
          per_next = per_reg + 5'h01;
          if (per_reg == 5'(`SCADC_PULSES - 1)) begin
            state_next = scadc_pkg::SCADC_H_TAIL;
          end
        end
      end
      scadc_pkg::SCADC_H_TAIL: begin
        if (div_reg == 3'(`SCADC_PERIOD_CYC - 1)) begin
          per_next = per_reg + 5'h01;
          if (per_reg == 5'(`SCADC_SAMPLES - 1)) begin
            state_next = scadc_pkg::SCADC_H_DONE;
          end
        end
      end
      scadc_pkg::SCADC_H_DONE: begin
        // take the first phase whose header decodes cleanly
        err_next = 1'h1;
        for (int p = 2; p >= 0; p--) begin
          if (dec[p][16]) begin
            res_next = dec[p][15:0];
            ph_next = 2'(p);
            err_next = 1'h0;
          end
        end
        // discard the first result and spoiled ones
        valid_next = first_reg && !spoil_reg && !err_next;
        first_next = 1'h1;
        state_next = scadc_pkg::SCADC_H_IDLE;
      end
      default: begin
        state_next = scadc_pkg::SCADC_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= scadc_pkg::SCADC_H_IDLE;
      cnt_reg <= 16'h0000;
      div_reg <= 3'h0;
      per_reg <= 5'h00;
      lclk_reg <= `SCADC_CLK_IDLE;
      cnv_reg <= 1'h0;
      cap_reg <= '{default: 24'h000000};
      gap_reg <= 16'(`SCADC_CONV_PERIOD_CYC);
      first_reg <= 1'h0;
      spoil_reg <= 1'h0;
      res_reg <= 16'h0000;
      valid_reg <= 1'h0;
      err_reg <= 1'h0;
      ph_reg <= 2'h0;
    end else if (ce_i) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      div_reg <= div_next;
      per_reg <= per_next;
      lclk_reg <= lclk_next;
      cnv_reg <= cnv_next;
      cap_reg <= cap_next;
      gap_reg <= gap_next;
      first_reg <= first_next;
      spoil_reg <= spoil_next;
      res_reg <= res_next;
      valid_reg <= valid_next;
      err_reg <= err_next;
      ph_reg <= ph_next;
    end
  end

  // ready is registered so a request in idle is taken on the next edge
  logic ready_reg;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_reg <= 1'h0;
    end else if (ce_i) begin
      ready_reg <= (state_next == scadc_pkg::SCADC_H_IDLE);
    end
  end

  assign link.conv_start = cnv_reg;
  assign link.link_clk = lclk_reg;
  assign ready_o = ready_reg;
  assign result_o = res_reg;
  assign valid_o = valid_reg;
  assign error_o = err_reg;
  assign phase_o = ph_reg;

endmodule : scadc_host
`default_nettype wire

// *** verification/scadc_link_checker.sv ***
// Purpose: protocol checks on the link between host and converter
// Assumes: the host clock samples all three link wires
// Notes: falls per burst are counted in helper flops
`default_nettype none
module scadc_link_checker (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic conv_start,
  input wire logic link_clk,
  input wire logic data
);
  logic [4:0] fall_cnt_reg, fall_cnt_next;
  logic clk_prev_reg, clk_prev_next;
  logic start_prev_reg, start_prev_next;
  logic started_reg, started_next;

  // falls since last start; saturates so a runaway burst stays visible
  always_comb begin
    clk_prev_next = link_clk;
    start_prev_next = conv_start;
    started_next = started_reg | conv_start;
    fall_cnt_next = fall_cnt_reg;
    if (conv_start && !start_prev_reg) begin
      fall_cnt_next = 5'h00;
    end else if (clk_prev_reg && !link_clk && fall_cnt_reg != 5'h1F) begin
      fall_cnt_next = fall_cnt_reg + 5'h01;
    end
  end

  // helper registers, idle values match the link reset levels
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fall_cnt_reg <= 5'h00;
      clk_prev_reg <= 1'h1;
      start_prev_reg <= 1'h0;
      started_reg <= 1'h0;
    end else begin
      fall_cnt_reg <= fall_cnt_next;
      clk_prev_reg <= clk_prev_next;
      start_prev_reg <= start_prev_next;
      started_reg <= started_next;
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  // one link clock low phase of three host cycles
  sequence s_low_phase;
    !link_clk [*3] ##1 link_clk;
  endsequence
  sequence s_hdr_one;
    ##5 data;
  endsequence
  sequence s_hdr_zero;
    ##5 !data;
  endsequence

  property p_start_pulse;
    $rose(conv_start) |-> ##2 !conv_start [*8];
  endproperty
  property p_clk_quiet;
    $rose(conv_start) |-> link_clk [*8] ##1 link_clk [*6];
  endproperty
  property p_burst_count;
    $rose(conv_start) && started_reg |-> fall_cnt_reg == 5'h12;
  endproperty
  property p_fall_limit;
    fall_cnt_reg <= 5'h12;
  endproperty
  property p_lead_zero;
    $fell(link_clk) && fall_cnt_reg == 5'h00 |-> !data;
  endproperty
  property p_hdr_one;
    $fell(link_clk) && fall_cnt_reg == 5'h00 |-> s_hdr_one;
  endproperty
  property p_hdr_zero;
    $fell(link_clk) && fall_cnt_reg == 5'h01 |-> s_hdr_zero;
  endproperty
  property p_bit_stable;
    $fell(link_clk) && fall_cnt_reg < 5'h12 |-> ##5 $stable(data);
  endproperty
  property p_pulse_shape;
    $fell(link_clk) |-> s_low_phase ##1 link_clk [*2];
  endproperty
  property p_idle_high;
    $fell(link_clk) && fall_cnt_reg == 5'h11 |-> s_low_phase ##1 link_clk [*8];
  endproperty

  a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
  a_clk_quiet: assert property (p_clk_quiet) else $error("clock before ready");
  a_burst_count: assert property (p_burst_count) else $error("burst not 18");
  a_fall_limit: assert property (p_fall_limit) else $error("too many falls");
  a_lead_zero: assert property (p_lead_zero) else $error("lead zero missing");
  a_hdr_one: assert property (p_hdr_one) else $error("header one missing");
  a_hdr_zero: assert property (p_hdr_zero) else $error("header zero missing");
  a_bit_stable: assert property (p_bit_stable) else $error("data moved late");
  a_pulse_shape: assert property (p_pulse_shape) else $error("bad clock pulse");
  a_idle_high: assert property (p_idle_high) else $error("clock not idle high");
endmodule // scadc_link_checker
`default_nettype wire

// *** verification/tb_self_clocked_adc_serial_readout.sv ***
// Purpose: host and converter ends joined, plus a converter driven by the bench
// Assumes: one 40 MHz clock; bench link clock of 200 ns on the second link
// Notes: first and stale results are expected to come out not valid
`default_nettype none
module tb_self_clocked_adc_serial_readout;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic ce_i = 1'h1;
  logic start_i = 1'h0;
  logic [15:0] sample_a = 16'h0000;
  logic [15:0] sample_b = 16'h0000;
  logic ready_o, valid_o, error_o, busy_b, shift_b;
  logic [15:0] result_o;
  logic [15:0] v;
  logic [1:0] phase_o;
  integer seed = 32'hC4E536CE;
  int error_cnt = 0;
  int n_checks = 0;
  int k;
  logic [15:0] exp_q[$];
  scadc_link_if link_a();
  scadc_link_if link_b();

  scadc_device scadc_device_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .sample_i(sample_a), .busy_o(), .shifting_o(), .link(link_a.device));
  scadc_host scadc_host_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .start_i(start_i), .ready_o(ready_o), .result_o(result_o), .valid_o(valid_o),
    .error_o(error_o), .phase_o(phase_o), .link(link_a.host));
  // second converter: the bench plays a host that breaks the rules
  scadc_device scadc_device_inst_b (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .sample_i(sample_b), .busy_o(busy_b), .shifting_o(shift_b), .link(link_b.device));
  scadc_link_checker scadc_link_checker_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .conv_start(link_a.conv_start), .link_clk(link_a.link_clk), .data(link_a.data));

  // clock and idle levels of the bench driven link
  initial begin
    link_b.conv_start = 1'h0;
    link_b.link_clk = 1'h1;
    forever #12.5 clock_i = ~clock_i;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // bounded wait; running out ends the run as a failure
  task automatic wait_lvl(ref logic s, input logic lvl);
    int i;
    for (i = 0; i < 2000 && s !== lvl; i++) @(posedge clock_i);
    if (s !== lvl) begin
      error_cnt++;
      $display("ERROR t=%0t wait ran out", $time);
      end_of_test();
    end
  endtask

  // one host readout; a start while busy must be refused
  task automatic host_read(input bit keep);
    logic [15:0] w;
    w = 16'($random(seed));
    wait_lvl(ready_o, 1'h1);
    @(posedge clock_i);
    start_i <= 1'h1;
    sample_a <= w;
    @(posedge clock_i);
    start_i <= 1'h0;
    if (keep) exp_q.push_back(w);
    repeat (4) @(posedge clock_i);
    // freeze both ends while converting; the word must come through unchanged
    ce_i <= 1'h0;
    repeat (5) @(posedge clock_i);
    ce_i <= 1'h1;
    repeat (11) @(posedge clock_i);
    start_i <= 1'h1;
    @(posedge clock_i);
    start_i <= 1'h0;
    wait_lvl(ready_o, 1'h1);
  endtask

  // start pulse of two cycles: long enough for the filter, within the high time limit
  task automatic dev_start(input logic [15:0] w);
    @(posedge clock_i);
    link_b.conv_start <= 1'h1;
    sample_b <= w;
    repeat (2) @(posedge clock_i);
    link_b.conv_start <= 1'h0;
  endtask

  // 18 pulses of 8 cycles (200 ns); each bit is read just before the next fall
  task automatic dev_burst(input logic [15:0] w);
    logic [17:0] bits;
    int i;
    bits = {2'b10, w};
    check(link_b.data, 1'h0);
    @(posedge clock_i);
    for (i = 17; i >= 0; i--) begin
      link_b.link_clk <= 1'h0;
      repeat (4) @(posedge clock_i);
      link_b.link_clk <= 1'h1;
      repeat (4) @(posedge clock_i);
      check(link_b.data, bits[i]);
    end
    check(shift_b, 1'h0);
  endtask

  // result watcher: each valid pulse takes the oldest expected word
  always @(posedge clock_i) begin
    if (valid_o === 1'h1) begin
      if (exp_q.size() == 0) begin
        check(1'h1, 1'h0);
      end else begin
        check(result_o, exp_q.pop_front());
        check(error_o, 1'h0);
        check(phase_o != 2'h3, 1'h1);
      end
    end
  end

  initial begin
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'h1;
    host_read(1'b0);
    for (k = 0; k < 4; k++) host_read(1'b1);
    repeat (500) @(posedge clock_i);
    host_read(1'b0);
    host_read(1'b1);
    // first result of the second converter is sent as zero
    dev_start(16'($random(seed)));
    wait_lvl(shift_b, 1'h1);
    dev_burst(16'h0000);
    v = 16'($random(seed));
    dev_start(v);
    repeat (3) @(posedge clock_i);
    check(busy_b, 1'h1);
    dev_start(~v);
    wait_lvl(shift_b, 1'h1);
    dev_burst(v);
    dev_start(16'($random(seed)));
    wait_lvl(shift_b, 1'h1);
    repeat (20) @(posedge clock_i);
    v = 16'($random(seed));
    dev_start(v);
    wait_lvl(busy_b, 1'h1);
    // the unclocked word is dropped at the deadline, before the new one is ready
    wait_lvl(shift_b, 1'h0);
    check(busy_b, 1'h1);
    wait_lvl(busy_b, 1'h0);
    dev_burst(v);
    repeat (4) @(posedge clock_i);
    check(16'(exp_q.size()), 16'h0000);
    end_of_test();
  end
endmodule // tb_self_clocked_adc_serial_readout
`default_nettype wire
